// *** design/utlc_bit_timer.v ***
// one-shot counter of bit periods with busy level and done pulse
`timescale 1ns/100ps
module utlc_bit_timer #(
  parameter W = 8
) (
  input wire clk,
  input wire reset_n,
  input wire start,
  input wire cancel,
  input wire tick,
  input wire [W-1:0] limit,
  output reg busy_r,
  output reg done_r
);
  reg [W-1:0] cnt_r;

  always @(posedge clk)
  begin
    if (!reset_n || cancel)
    begin
      cnt_r <= {W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      // a zero limit never arms the timer
      if (start && limit != {W{1'b0}})
      begin
        cnt_r <= limit;
        busy_r <= 1'b1;
      end
      else if (busy_r && tick)
      begin
        if (cnt_r == {{(W-1){1'b0}}, 1'b1})
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// *** design/utlc_frac_div.v ***
// divider with eighth-step fractional period, advancing on an enable
`timescale 1ns/100ps
module utlc_frac_div #(
  parameter W = 16
) (
  input wire clk,
  input wire reset_n,
  input wire run,
  input wire restart,
  input wire adv,
  input wire [W-1:0] divisor,
  input wire [2:0] frac,
  output reg tick_r
);
  reg [W-1:0] cnt_r;
  reg [2:0] acc_r;
  reg ext_r;
  wire [W:0] last_w;
  wire [3:0] acc_sum_w;

  // one extra cycle whenever the eighths accumulator overflows
  assign last_w = {1'b0, divisor} - {{W{1'b0}}, 1'b1} + {{W{1'b0}}, ext_r};
  assign acc_sum_w = {1'b0, acc_r} + {1'b0, frac};

  always @(posedge clk)
  begin
    if (!reset_n || !run || restart || divisor == {W{1'b0}})
    begin
      cnt_r <= {W{1'b0}};
      acc_r <= 3'h0;
      ext_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= 1'b0;
      if (adv)
      begin
        if ({1'b0, cnt_r} >= last_w)
        begin
          cnt_r <= {W{1'b0}};
          tick_r <= 1'b1;
          acc_r <= acc_sum_w[2:0];
          ext_r <= acc_sum_w[3];
        end
        else
        begin
          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// *** design/utlc_map.vh ***
// register offsets, field positions, reset values and timing for utlc
`ifndef UTLC_MAP_VH
`define UTLC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UTLC_OFS_DIVIDER 8'h20
`define UTLC_OFS_IDLE 8'h24
`define UTLC_OFS_GUARD 8'h28
`define UTLC_OFS_RATIO 8'h40
`define UTLC_OFS_TALLY 8'h44
`define UTLC_OFS_IRF 8'h4c
`define UTLC_OFS_BIPHASE 8'h50
`define UTLC_OFS_LINE_MODE 8'h60
`define UTLC_OFS_LOCK 8'h64
`define UTLC_OFS_CMD 8'h68
`define UTLC_OFS_STATUS 8'h6c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UTLC_CD_RANGE 15:0
`define UTLC_FP_RANGE 18:16
`define UTLC_TO_RANGE 16:0
`define UTLC_TG_RANGE 7:0
`define UTLC_RATIO_RANGE 10:0
`define UTLC_IRF_RANGE 7:0
`define UTLC_BP_DRIFT 30
`define UTLC_BP_RXPOL 28
`define UTLC_BP_RXPP 25:24
`define UTLC_BP_RXPL 19:16
`define UTLC_BP_TXPOL 12
`define UTLC_BP_TXPP 9:8
`define UTLC_BP_TXPL 3:0
`define UTLC_BP_WMASK 32'h530f130f
`define UTLC_BP_FIXED 32'h20000000
`define UTLC_LM_CODE 3:0
`define UTLC_LM_SYNC 4
`define UTLC_LM_OVER 5
`define UTLC_CMD_ARM 0
`define UTLC_CMD_REARM 1

// ----------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------
`define UTLC_RST_RATIO 11'h174
`define UTLC_RST_BIPHASE 32'h30011004
`define UTLC_MODE_CARD_A 4'h4
`define UTLC_MODE_CARD_B 4'h6
`define UTLC_MODE_SPI_M 4'he
`define UTLC_MODE_SPI_S 4'hf

// ----------------------------------------------------------------
// timing: samples per bit in asynchronous mode
// ----------------------------------------------------------------
`define UTLC_OVS_NORMAL 11'h010
`define UTLC_OVS_HALF 11'h008

`endif

// *** design/utlc_top.v ***
// serial line timing and configuration core: dividers, timers, biphase
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "utlc_map.vh"

module utlc_top (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  input wire rx_char_pulse,
  input wire tx_char_done,
  input wire card_fault_pulse,
  input wire tx_pre_start,
  input wire ir_rx_pin,
  input wire rx_biphase_pin,
  output wire samp_tick_r,
  output wire baud_tick_r,
  output wire tx_guard_busy_r,
  output reg idle_timeout_r,
  output reg ir_rx_filt_r,
  output reg tx_biphase_line_r,
  output reg tx_pre_active_r,
  output reg rx_pre_found_r
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [15:0] clock_divisor_r;
  reg [2:0] fraction_eighths_r;
  reg [16:0] rx_idle_limit_r;
  reg [7:0] guard_gap_len_r;
  reg [10:0] smartcard_clock_ratio_r;
  reg [7:0] card_fault_tally_r;
  reg [7:0] ir_filter_r;
  reg [31:0] biphase_r;
  reg [3:0] mode_code_r;
  reg sync_mode_r;
  reg half_samp_r;
  reg write_lock_on_r;
  reg armed_r;
  reg [31:0] rd_nxt;

  wire wr_cfg;
  wire arm_idle_timer_cmd;
  wire rearm_idle_timer_cmd;
  wire rd_status;
  wire rd_tally;

  // locked writes simply drop; nothing reports the violation here
  assign wr_cfg = reg_wr && !write_lock_on_r;
  assign arm_idle_timer_cmd = reg_wr && reg_addr == `UTLC_OFS_CMD &&
                              reg_wdata[`UTLC_CMD_ARM];
  assign rearm_idle_timer_cmd = reg_wr && reg_addr == `UTLC_OFS_CMD &&
                                reg_wdata[`UTLC_CMD_REARM];
  assign rd_status = reg_rd && reg_addr == `UTLC_OFS_STATUS;
  assign rd_tally = reg_rd && reg_addr == `UTLC_OFS_TALLY;

  wire drift_on = biphase_r[`UTLC_BP_DRIFT];
  wire rx_biphase_polarity = biphase_r[`UTLC_BP_RXPOL];
  wire [1:0] rx_preamble_shape = biphase_r[`UTLC_BP_RXPP];
  wire [3:0] rx_preamble_len = biphase_r[`UTLC_BP_RXPL];
  wire tx_biphase_polarity = biphase_r[`UTLC_BP_TXPOL];
  wire [1:0] tx_preamble_shape = biphase_r[`UTLC_BP_TXPP];
  wire [3:0] tx_preamble_len = biphase_r[`UTLC_BP_TXPL];

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      clock_divisor_r <= 16'h0000;
      fraction_eighths_r <= 3'h0;
      rx_idle_limit_r <= 17'h00000;
      guard_gap_len_r <= 8'h00;
      smartcard_clock_ratio_r <= `UTLC_RST_RATIO;
      ir_filter_r <= 8'h00;
      biphase_r <= `UTLC_RST_BIPHASE;
      mode_code_r <= 4'h0;
      sync_mode_r <= 1'b0;
      half_samp_r <= 1'b0;
      write_lock_on_r <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `UTLC_OFS_LOCK)
        write_lock_on_r <= reg_wdata[0];
      if (wr_cfg)
      begin
        case (reg_addr)
          `UTLC_OFS_DIVIDER:
          begin
            clock_divisor_r <= reg_wdata[`UTLC_CD_RANGE];
            fraction_eighths_r <= reg_wdata[`UTLC_FP_RANGE];
          end
          `UTLC_OFS_IDLE: rx_idle_limit_r <= reg_wdata[`UTLC_TO_RANGE];
          `UTLC_OFS_GUARD: guard_gap_len_r <= reg_wdata[`UTLC_TG_RANGE];
          `UTLC_OFS_RATIO:
            smartcard_clock_ratio_r <= reg_wdata[`UTLC_RATIO_RANGE];
          `UTLC_OFS_IRF: ir_filter_r <= reg_wdata[`UTLC_IRF_RANGE];
          `UTLC_OFS_BIPHASE:
            biphase_r <= (reg_wdata & `UTLC_BP_WMASK) | `UTLC_BP_FIXED;
          `UTLC_OFS_LINE_MODE:
          begin
            mode_code_r <= reg_wdata[`UTLC_LM_CODE];
            sync_mode_r <= reg_wdata[`UTLC_LM_SYNC];
            half_samp_r <= reg_wdata[`UTLC_LM_OVER];
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // bit rate generation
  // ----------------------------------------------------------------
  wire spi_mode = mode_code_r == `UTLC_MODE_SPI_M ||
                  mode_code_r == `UTLC_MODE_SPI_S;
  wire direct_mode = sync_mode_r || spi_mode;
  wire card_mode = !direct_mode && (mode_code_r == `UTLC_MODE_CARD_A ||
                                    mode_code_r == `UTLC_MODE_CARD_B);
  wire async_plain = !direct_mode && !card_mode;
  reg [10:0] post_lim;
  wire [10:0] half_lim;
  wire [2:0] frac_use;
  wire half_tick;
  reg drift_restart;

  always @*
  begin
    if (direct_mode)
      post_lim = 11'h001;
    else if (card_mode)
      post_lim = smartcard_clock_ratio_r;
    else if (half_samp_r)
      post_lim = `UTLC_OVS_HALF;
    else
      post_lim = `UTLC_OVS_NORMAL;
  end

  // fraction only refines the asynchronous formulas
  assign frac_use = async_plain ? fraction_eighths_r : 3'h0;
  assign half_lim = (post_lim[10:1] == 10'h000) ? 11'h001 :
                    {1'b0, post_lim[10:1]};

  // stage one: clock divided by divisor; zero divisor holds it off
  utlc_frac_div #(.W(16)) u_samp_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(1'b1),
    .restart(1'b0),
    .adv(1'b1),
    .divisor(clock_divisor_r),
    .frac(frac_use),
    .tick_r(samp_tick_r)
  );

  // stage two: per-mode postscale; zero card ratio stops the bit clock
  utlc_frac_div #(.W(11)) u_baud_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(1'b1),
    .restart(1'b0),
    .adv(samp_tick_r),
    .divisor(post_lim),
    .frac(3'h0),
    .tick_r(baud_tick_r)
  );

  // half-bit tick for the biphase coder; odd postscales above one round down
  utlc_frac_div #(.W(11)) u_half_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(post_lim != 11'h000),
    .restart(drift_restart),
    .adv(samp_tick_r),
    .divisor(half_lim),
    .frac(3'h0),
    .tick_r(half_tick)
  );

  // ----------------------------------------------------------------
  // receive idle time-out and transmit guard gap
  // ----------------------------------------------------------------
  wire idle_done;
  wire idle_start = rearm_idle_timer_cmd || (armed_r && rx_char_pulse);

  utlc_bit_timer #(.W(17)) u_idle_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(idle_start),
    .cancel(arm_idle_timer_cmd && !rearm_idle_timer_cmd),
    .tick(baud_tick_r),
    .limit(rx_idle_limit_r),
    .busy_r(),
    .done_r(idle_done)
  );

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      idle_timeout_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      // for the flag, expiry beats a command landing in the same cycle; for armed_r the command wins
      if (idle_done)
        idle_timeout_r <= 1'b1;
      else if (arm_idle_timer_cmd || rearm_idle_timer_cmd)
        idle_timeout_r <= 1'b0;
      if (arm_idle_timer_cmd || rearm_idle_timer_cmd)
        armed_r <= 1'b1;
      else if (idle_done)
        armed_r <= 1'b0;
    end
  end

  utlc_bit_timer #(.W(8)) u_guard_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(tx_char_done),
    .cancel(1'b0),
    .tick(baud_tick_r),
    .limit(guard_gap_len_r),
    .busy_r(tx_guard_busy_r),
    .done_r()
  );

  // ----------------------------------------------------------------
  // card fault tally, cleared by reading; a fault in that cycle counts
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
      card_fault_tally_r <= 8'h00;
    else if (card_fault_pulse && rd_tally)
      card_fault_tally_r <= 8'h01;
    else if (rd_tally)
      card_fault_tally_r <= 8'h00;
    else if (card_fault_pulse && card_fault_tally_r != 8'hff)
      card_fault_tally_r <= card_fault_tally_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // pin synchronisers and infrared glitch filter
  // ----------------------------------------------------------------
  reg [2:0] ir_sync_r;
  reg [2:0] rx_sync_r;
  reg ir_lvl_r;
  reg rx_lvl_r;
  reg rx_lvl_d_r;
  reg [7:0] ir_cnt_r;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      ir_sync_r <= 3'h7;
      rx_sync_r <= 3'h7;
      ir_lvl_r <= 1'b1;
      rx_lvl_r <= 1'b1;
      rx_lvl_d_r <= 1'b1;
      ir_cnt_r <= 8'h00;
      ir_rx_filt_r <= 1'b1;
    end
    else
    begin
      ir_sync_r <= {ir_sync_r[1:0], ir_rx_pin};
      rx_sync_r <= {rx_sync_r[1:0], rx_biphase_pin};
      if (ir_sync_r[1] == ir_sync_r[2])
        ir_lvl_r <= ir_sync_r[2];
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_lvl_r <= rx_sync_r[2];
      rx_lvl_d_r <= rx_lvl_r;
      // a new level must persist past the filter count to pass
      if (ir_lvl_r == ir_rx_filt_r)
        ir_cnt_r <= 8'h00;
      else if (ir_cnt_r >= ir_filter_r)
      begin
        ir_rx_filt_r <= ir_lvl_r;
        ir_cnt_r <= 8'h00;
      end
      else
        ir_cnt_r <= ir_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // biphase preamble generation
  // ----------------------------------------------------------------
  function pat_bit;
    input [1:0] shape;
    input [3:0] idx;
    begin
      pat_bit = shape[1] ? (idx[0] ^ shape[0]) : ~shape[0];
    end
  endfunction

  localparam TX_IDLE = 3'b001;
  localparam TX_FIRST = 3'b010;
  localparam TX_SECOND = 3'b100;
  reg [2:0] tx_state_r;
  reg [3:0] tx_idx_r;
  wire tx_bit = pat_bit(tx_preamble_shape, tx_idx_r);

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_state_r <= TX_IDLE;
      tx_idx_r <= 4'h0;
      tx_biphase_line_r <= 1'b1;
      tx_pre_active_r <= 1'b0;
    end
    else
    begin
      case (tx_state_r)
        TX_IDLE:
        begin
          tx_idx_r <= 4'h0;
          if (half_tick)
            tx_biphase_line_r <= 1'b1;
          if (tx_pre_start && tx_preamble_len != 4'h0)
          begin
            tx_state_r <= TX_FIRST;
            tx_pre_active_r <= 1'b1;
          end
        end
        TX_FIRST:
          if (half_tick)
          begin
            tx_biphase_line_r <= tx_bit ^ tx_biphase_polarity;
            tx_state_r <= TX_SECOND;
          end
        TX_SECOND:
          if (half_tick)
          begin
            tx_biphase_line_r <= ~(tx_bit ^ tx_biphase_polarity);
            tx_idx_r <= tx_idx_r + 4'h1;
            if (tx_idx_r == tx_preamble_len - 4'h1)
            begin
              tx_state_r <= TX_IDLE;
              tx_pre_active_r <= 1'b0;
            end
            else
              tx_state_r <= TX_FIRST;
          end
        default:
        begin
          tx_state_r <= TX_IDLE;
          tx_pre_active_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // biphase preamble detection with optional drift resync
  // ----------------------------------------------------------------
  reg rx_ph_r;
  reg rx_h1_r;
  reg [3:0] rx_cnt_r;
  wire rx_bit = rx_h1_r ^ rx_biphase_polarity;
  wire rx_exp = pat_bit(rx_preamble_shape, rx_cnt_r);

  // resync on the mid-bit edge; coarse, but bounded to one half bit
  always @*
  begin
    drift_restart = drift_on && async_plain && !half_samp_r &&
                    rx_ph_r && rx_lvl_r != rx_lvl_d_r;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_ph_r <= 1'b0;
      rx_h1_r <= 1'b1;
      rx_cnt_r <= 4'h0;
      rx_pre_found_r <= 1'b0;
    end
    else
    begin
      if (rd_status)
        rx_pre_found_r <= 1'b0;
      if (half_tick)
      begin
        rx_ph_r <= ~rx_ph_r;
        if (!rx_ph_r)
          rx_h1_r <= rx_lvl_r;
        else if (rx_preamble_len == 4'h0 || rx_h1_r == rx_lvl_r)
          rx_cnt_r <= 4'h0;
        else if (rx_bit != rx_exp)
          rx_cnt_r <= 4'h0;
        else if (rx_cnt_r == rx_preamble_len - 4'h1)
        begin
          rx_cnt_r <= 4'h0;
          rx_pre_found_r <= 1'b1;
        end
        else
          rx_cnt_r <= rx_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port, data valid the cycle after the strobe
  // ----------------------------------------------------------------
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (reg_addr)
      `UTLC_OFS_DIVIDER:
        rd_nxt = {13'h0000, fraction_eighths_r, clock_divisor_r};
      `UTLC_OFS_IDLE: rd_nxt = {15'h0000, rx_idle_limit_r};
      `UTLC_OFS_GUARD: rd_nxt = {24'h000000, guard_gap_len_r};
      `UTLC_OFS_RATIO: rd_nxt = {21'h000000, smartcard_clock_ratio_r};
      `UTLC_OFS_TALLY: rd_nxt = {24'h000000, card_fault_tally_r};
      `UTLC_OFS_IRF: rd_nxt = {24'h000000, ir_filter_r};
      `UTLC_OFS_BIPHASE: rd_nxt = biphase_r;
      `UTLC_OFS_LINE_MODE:
        rd_nxt = {26'h0000000, half_samp_r, sync_mode_r, mode_code_r};
      `UTLC_OFS_LOCK: rd_nxt = {31'h00000000, write_lock_on_r};
      `UTLC_OFS_STATUS:
        rd_nxt = {28'h0000000, write_lock_on_r, tx_guard_busy_r,
                  rx_pre_found_r, idle_timeout_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata_r <= 32'h00000000;
    else if (reg_rd)
      reg_rdata_r <= rd_nxt;
    else
      reg_rdata_r <= 32'h00000000;
  end
endmodule

// *** tb/usart_timing_and_line_config_tb.sv ***
// self-checking bench for utlc_top with a register model and line peer
`timescale 1ns/100ps
module usart_timing_and_line_config_tb;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg rx_char_pulse = 1'b0;
  reg tx_char_done = 1'b0;
  reg card_fault_pulse = 1'b0;
  reg tx_pre_start = 1'b0;
  reg ir_rx_pin = 1'b1;
  reg go = 1'b0;
  wire [31:0] reg_rdata_r;
  wire rx_biphase_pin, baud_tick_r, tx_guard_busy_r, idle_timeout_r;
  wire ir_rx_filt_r, tx_biphase_line_r, tx_pre_active_r, rx_pre_found_r;
  int mismatches = 0;
  int n_compared = 0;
  reg [31:0] mr [0:255];
  reg lk = 1'b0;
  reg b;
  reg [31:0] v;
  reg [15:0] sd = 16'h002b;
  int tal = 0;
  int i, j, n, c;
  reg [7:0] ad [0:9] = '{8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h4c,
    8'h50, 8'h60, 8'h64, 8'h30};
  int lm [0:7] = '{'h10, 'h0e, 0, 'h20, 0, 'h04, 'h0f, 'h06};
  int dv [0:7] = '{3, 'h50005, 2, 3, 'h40002, 2, 0, 2};
  int ra [0:7] = '{1, 1, 1, 1, 1, 3, 1, 0};
  int pe [0:7] = '{3, 5, 32, 24, 40, 6, 0, 0};
  // active drops as the last half bit goes out, so an all-ones preamble shows six of its seven edges
  int tr [0:3] = '{6, 7, 4, 3};

  utlc_top i_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .rx_char_pulse, .tx_char_done, .card_fault_pulse,
    .tx_pre_start, .ir_rx_pin, .rx_biphase_pin, .samp_tick_r(),
    .baud_tick_r, .tx_guard_busy_r, .idle_timeout_r, .ir_rx_filt_r,
    .tx_biphase_line_r, .tx_pre_active_r, .rx_pre_found_r);
  utlc_line_peer #(.HALF(4)) i_peer (.clk, .go, .line(rx_biphase_pin));

  always #5 clk = ~clk;
  // ----------------
  // model and helpers
  // ----------------
  function automatic [31:0] msk(input [7:0] a);
    case (a)
      8'h20: msk = 32'h0007ffff;
      8'h24: msk = 32'h0001ffff;
      8'h28, 8'h4c: msk = 32'h000000ff;
      8'h40: msk = 32'h000007ff;
      8'h50: msk = 32'h530f130f;
      8'h60: msk = 32'h0000003f;
      default: msk = 32'h0;
    endcase
  endfunction
  function automatic [31:0] exv(input [7:0] a);
    if (a == 8'h64)
      exv = {31'h0, lk};
    else if (a == 8'h44)
      exv = tal;
    else
      exv = mr[a] | (a == 8'h50 ? 32'h20000000 : 32'h0);
  endfunction
  function automatic [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task end_of_test;
    $display("compared %0d, wrong %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task ck(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  // strobes drop at the edge, the next request starts 1 ns later
  task wr(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    if (a == 8'h64)
      lk = d[0];
    else if (!lk)
      mr[a] = d & msk(a);
  endtask
  task rd(input [7:0] a, output [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask
  task rdc(input [7:0] a);
    rd(a, v);
    ck(v, exv(a));
    if (a == 8'h44)
      tal = 0;
  endtask
  task wt(output int t);
    t = 0;
    do
    begin
      @(posedge clk);
      #1 t++;
    end
    while (baud_tick_r !== 1'b1 && t < 3000);
    if (t >= 3000)
      t = 0;
  endtask
  // first two intervals after a change are thrown away
  task per(output int t);
    wt(t);
    wt(t);
    wt(t);
  endtask
  initial
  begin
    #600000;
    mismatches++;
    end_of_test;
  end
  // ----------------
  // tests
  // ----------------
  initial
  begin
    for (i = 0; i < 256; i++)
      mr[i] = 32'h0;
    mr[8'h40] = 32'h174;
    mr[8'h50] = 32'h30011004;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i++)
      rdc(ad[i]);
    $display("reset values done");
    for (i = 0; i < 60; i++)
    begin
      sd = nx(sd);
      j = sd % 10;
      sd = nx(sd);
      wr(ad[j], {sd, nx(sd)});
      rdc(ad[j]);
    end
    wr(8'h64, 32'h0);
    rd(8'h6c, v);
    ck(v[3], 0);
    $display("locking done");
    for (i = 0; i < 3; i++)
    begin
      card_fault_pulse <= 1'b1;
      @(posedge clk);
      card_fault_pulse <= 1'b0;
      @(posedge clk);
      tal++;
    end
    rdc(8'h44);
    rdc(8'h44);
    $display("tally done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h40, ra[i]);
      wr(8'h20, dv[i]);
      wr(8'h60, lm[i]);
      per(n);
      ck(n, pe[i]);
    end
    $display("rates done");
    wr(8'h20, 32'h4);
    wr(8'h60, 32'h10);
    wr(8'h28, 32'h3);
    tx_char_done <= 1'b1;
    @(posedge clk);
    tx_char_done <= 1'b0;
    n = 0;
    repeat (40) @(posedge clk) #1 n += tx_guard_busy_r;
    ck(n > 8 && n <= 12, 1);
    wr(8'h24, 32'h5);
    wr(8'h68, 32'h1);
    rx_char_pulse <= 1'b1;
    @(posedge clk);
    rx_char_pulse <= 1'b0;
    n = 0;
    while (idle_timeout_r !== 1'b1 && n < 100) @(posedge clk) #1 n++;
    ck(n > 16 && n <= 24, 1);
    rd(8'h6c, v);
    ck(v[0], 1);
    wr(8'h24, 32'h0);
    wr(8'h68, 32'h2);
    repeat (60) @(posedge clk);
    #1 ck(idle_timeout_r, 0);
    $display("timers done");
    wr(8'h20, 32'h1);
    wr(8'h60, 32'h20);
    for (i = 0; i < 8; i++)
    begin
      wr(8'h50, 32'h40004 | (i[2] << 12) | (i[1:0] << 8));
      tx_pre_start <= 1'b1;
      @(posedge clk);
      tx_pre_start <= 1'b0;
      n = 0;
      c = 0;
      b = tx_biphase_line_r;
      repeat (50)
      begin
        @(posedge clk);
        #1 n += tx_pre_active_r;
        c += (tx_pre_active_r && tx_biphase_line_r !== b);
        b = tx_biphase_line_r;
      end
      ck(c, tr[(i & 3) ^ (i >> 2)]);
      ck(n >= 28 && n <= 32, 1);
    end
    wr(8'h50, 32'h40004);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (150) @(posedge clk);
    rd(8'h6c, v);
    ck(v[1], 1);
    rd(8'h6c, v);
    ck(v[1], 0);
    $display("biphase done");
    wr(8'h4c, 32'h3);
    ir_rx_pin <= 1'b0;
    repeat (2) @(posedge clk);
    ir_rx_pin <= 1'b1;
    c = 0;
    repeat (12) @(posedge clk) #1 c += !ir_rx_filt_r;
    ck(c, 0);
    ir_rx_pin <= 1'b0;
    repeat (12) @(posedge clk);
    #1 ck(ir_rx_filt_r, 0);
    ir_rx_pin <= 1'b1;
    $display("infrared done");
    end_of_test;
  end
endmodule

// *** tb/utlc_line_peer.sv ***
// biphase line peer sending a preamble of ones
`timescale 1ns/100ps
module utlc_line_peer #(
  parameter HALF = 4
) (
  input wire clk,
  input wire go,
  output reg line
);
  integer i;
  initial line = 1'b1;
  // one extra low half mid-stream shifts the framing, so one of the
  // two blocks decodes as ones whatever the receiver's half phase
  always @(posedge go)
  begin
    for (i = 0; i < 33; i = i + 1)
    begin
      @(posedge clk);
      line <= (i < 16) ? ~i[0] : (i == 16) ? 1'b0 : i[0];
      repeat (HALF - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
  end
endmodule

// *** tb/utlc_top_monitor.sv ***
// assertion checker for utlc_top, bound to its ports
`timescale 1ns/100ps
module utlc_chk (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_r,
  input wire tx_char_done,
  input wire card_fault_pulse,
  input wire tx_pre_start,
  input wire samp_tick_r,
  input wire baud_tick_r,
  input wire tx_guard_busy_r,
  input wire idle_timeout_r,
  input wire tx_pre_active_r,
  input wire rx_pre_found_r
);
  // ----------------
  // bus steps
  // ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence rd_tally;
    reg_rd && reg_addr == 8'h44 && !card_fault_pulse;
  endsequence
  sequence wr_lock;
    reg_wr && reg_addr == 8'h64;
  endsequence
  sequence rd_stat;
    reg_rd && reg_addr == 8'h6c;
  endsequence
  // ----------------
  // checks
  // ----------------
  tally_clear_a: assert property (rd_tally ##1 rd_tally |=>
    reg_rdata_r == 32'h0) else $error("tally kept after read");
  lock_status_a: assert property (wr_lock ##1 rd_stat |=>
    reg_rdata_r[3] == $past(reg_wdata[0], 2)) else $error("lock state");
  guard_start_a: assert property ($rose(tx_guard_busy_r) |->
    $past(tx_char_done)) else $error("guard gap without cause");
  guard_end_a: assert property ($fell(tx_guard_busy_r) |->
    $past(baud_tick_r) || $past(baud_tick_r, 2)) else $error("guard end");
  pre_start_a: assert property ($rose(tx_pre_active_r) |->
    $past(tx_pre_start)) else $error("preamble without start");
  timeout_rise_a: assert property ($rose(idle_timeout_r) |->
    $past(baud_tick_r) || $past(baud_tick_r, 2)) else $error("timeout");
  timeout_clear_a: assert property ($fell(idle_timeout_r) |->
    $past(reg_wr) && $past(reg_addr) == 8'h68) else $error("flag lost");
  found_clear_a: assert property ($fell(rx_pre_found_r) |->
    $past(reg_rd) && $past(reg_addr) == 8'h6c) else $error("found lost");
  baud_src_a: assert property (baud_tick_r |-> $past(samp_tick_r))
    else $error("bit tick without sample tick");
endmodule

bind utlc_top utlc_chk i_chk (.clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata_r, .tx_char_done, .card_fault_pulse,
  .tx_pre_start, .samp_tick_r, .baud_tick_r, .tx_guard_busy_r,
  .idle_timeout_r,
  .tx_pre_active_r, .rx_pre_found_r);
